// ---- src/counter_mode_sequencer.sv ----
// Mode sequencer for one down counter: modes A, B, D, E, F and G.
// Assumes a host on the plain register port and asynchronous source
// and gate pins.
`timescale 1ns/1ps
module counter_mode_sequencer
  import ctr_seq_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [DATA_W-1:0] reg_rdata,
  input wire logic source_pin,
  input wire logic gate_pin,
  output logic terminal_count,
  output logic terminal_count_flip_output,
  output logic irq
);

  ////////////////////////////////////////////////////////////////////////

  typedef struct packed {
    logic [DATA_W-1:0] mode;
    logic [DATA_W-1:0] load;
    logic [DATA_W-1:0] hold;
    logic [DATA_W-1:0] count;
    logic [DATA_W-1:0] rdata;
    logic armed;
    logic running;
    logic use_hold;
    logic in_tc;
    logic stop_pend;
    logic disarm_pend;
    logic tc_out;
    logic flip;
    logic [IRQ_W-1:0] irq_stat;
    logic [IRQ_W-1:0] irq_mask;
    logic irq;
  } core_t;

  core_t st_r;
  core_t st_nxt;

  logic src_lvl;
  logic src_edge;
  logic gate_lvl;
  logic gate_edge;

  pin_sync u_src_sync (
    .clk_sys(clk_sys),
    .rst_b(rst_b),
    .pin_async(source_pin),
    .active_high(~st_r.mode[SRC_POL_POS]),
    .level(src_lvl),
    .rise(src_edge)
  );

  pin_sync u_gate_sync (
    .clk_sys(clk_sys),
    .rst_b(rst_b),
    .pin_async(gate_pin),
    .active_high(~st_r.mode[GATE_POL_POS]),
    .level(gate_lvl),
    .rise(gate_edge)
  );

  ////////////////////////////////////////////////////////////////////////

  logic [2:0] gate_ctl;
  logic rep_bit;
  logic rel_bit;
  logic edge_mode;
  logic level_mode;
  logic qualified;
  logic at_one;
  logic [IRQ_W-1:0] irq_evt;
  logic [DATA_W-1:0] irq_view;

  // Mode decode from the gate field and the repetition and reload source bits.
  assign gate_ctl = st_r.mode[GATE_CTL_HI:GATE_CTL_LO];
  assign rep_bit = st_r.mode[REPETITION_POS];
  assign rel_bit = st_r.mode[RELOAD_SRC_POS];
  assign edge_mode = (gate_ctl == GATE_EDGE);
  assign level_mode = (gate_ctl == GATE_LEVEL);
  assign at_one = (st_r.count == 16'h0001);
  assign irq_view = {{(DATA_W-IRQ_W){1'b0}}, st_r.irq_stat};

  always_comb
  begin
    st_nxt = st_r;
    irq_evt = '0;
    qualified = 1'b0;
    // A source edge is counted when armed and running, gated as the
    // mode asks; the terminal count state counts regardless.
    if (src_edge)
    begin
      if (st_r.in_tc)
      begin
        qualified = 1'b1;
      end
      else if (st_r.armed && st_r.running)
      begin
        qualified = level_mode ? gate_lvl : 1'b1;
      end
    end
    if (qualified)
    begin
      if (st_r.in_tc)
      begin
        // Leaving terminal count: apply a pending stop or disarm now.
        st_nxt.in_tc = 1'b0;
        st_nxt.tc_out = 1'b0;
        if (st_r.disarm_pend)
        begin
          st_nxt.armed = 1'b0;
          st_nxt.running = 1'b0;
          irq_evt[IRQ_DISARM_POS] = 1'b1;
        end
        else if (st_r.stop_pend)
        begin
          st_nxt.running = 1'b0;
        end
        st_nxt.disarm_pend = 1'b0;
        st_nxt.stop_pend = 1'b0;
        st_nxt.count = st_r.count - 16'h0001;
      end
      else if (at_one)
      begin
        st_nxt.in_tc = 1'b1;
        st_nxt.tc_out = 1'b1;
        st_nxt.flip = ~st_r.flip;
        irq_evt[IRQ_TC_POS] = 1'b1;
        if (rel_bit && !st_r.use_hold)
        begin
          st_nxt.count = st_r.hold;
          st_nxt.use_hold = 1'b1;
        end
        else
        begin
          st_nxt.count = st_r.load;
          st_nxt.use_hold = 1'b0;
          if (!rep_bit)
          begin
            st_nxt.disarm_pend = 1'b1;
          end
          else if (edge_mode)
          begin
            st_nxt.stop_pend = 1'b1;
          end
        end
      end
      else
      begin
        st_nxt.count = st_r.count - 16'h0001;
      end
    end
    // Edge gating: a gate edge starts an armed, halted counter.
    if (edge_mode && st_r.armed && !st_r.running && gate_edge)
    begin
      st_nxt.running = 1'b1;
    end
    // Register writes; arm, disarm and load are one-shot commands.
    if (reg_wr)
    begin
      case (reg_addr)
        OFS_MODE: st_nxt.mode = reg_wdata;
        OFS_LOAD: st_nxt.load = reg_wdata;
        OFS_HOLD: st_nxt.hold = reg_wdata;
        OFS_CMD:
        begin
          if (reg_wdata[CMD_LOAD_POS])
          begin
            st_nxt.count = st_r.load;
          end
          if (reg_wdata[CMD_DISARM_POS])
          begin
            st_nxt.armed = 1'b0;
            st_nxt.running = 1'b0;
            st_nxt.disarm_pend = 1'b0;
            st_nxt.stop_pend = 1'b0;
          end
          if (reg_wdata[CMD_ARM_POS])
          begin
            st_nxt.armed = 1'b1;
            st_nxt.running = !edge_mode;
            st_nxt.use_hold = 1'b0;
            st_nxt.disarm_pend = 1'b0;
            st_nxt.stop_pend = 1'b0;
          end
        end
        OFS_IRQ_STAT: st_nxt.irq_stat = st_r.irq_stat
                                        & ~reg_wdata[IRQ_W-1:0];
        OFS_IRQ_MASK: st_nxt.irq_mask = reg_wdata[IRQ_W-1:0];
        default: st_nxt.mode = st_nxt.mode;
      endcase
    end
    // Hardware set wins over a simultaneous software clear.
    st_nxt.irq_stat = st_nxt.irq_stat | irq_evt;
    st_nxt.irq = |(st_nxt.irq_stat & st_nxt.irq_mask);
    st_nxt.rdata = '0;
    if (reg_rd)
    begin
      case (reg_addr)
        OFS_MODE: st_nxt.rdata = st_r.mode;
        OFS_LOAD: st_nxt.rdata = st_r.load;
        OFS_HOLD: st_nxt.rdata = st_r.hold;
        OFS_COUNT: st_nxt.rdata = st_r.count;
        OFS_STATUS: st_nxt.rdata = {11'h000, st_r.flip, st_r.in_tc,
                                    st_r.use_hold, st_r.running,
                                    st_r.armed};
        OFS_IRQ_STAT: st_nxt.rdata = irq_view;
        OFS_IRQ_MASK: st_nxt.rdata = {{(DATA_W-IRQ_W){1'b0}},
                                      st_r.irq_mask};
        default: st_nxt.rdata = '0;
      endcase
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (!rst_b)
    begin
      st_r <= '0;
      st_r.mode <= MODE_RST;
      st_r.load <= LOAD_RST;
      st_r.hold <= HOLD_RST;
      st_r.count <= COUNT_RST;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  assign reg_rdata = st_r.rdata;
  assign terminal_count = st_r.tc_out;
  assign terminal_count_flip_output = st_r.flip;
  assign irq = st_r.irq;

  ////////////////////////////////////////////////////////////////////////
  // Checks.

  sequence s_tc_hit;
    st_r.armed && st_r.running && !st_r.in_tc && at_one && src_edge
      && (!level_mode || gate_lvl) && !reg_wr;
  endsequence

  property p_flip_on_tc;
    @(posedge clk_sys) disable iff (!rst_b)
      s_tc_hit |=> (terminal_count_flip_output != $past(st_r.flip));
  endproperty
  a_flip_on_tc: assert property (p_flip_on_tc)
    else $error("flip output did not toggle at terminal count");

  property p_tc_out;
    @(posedge clk_sys) disable iff (!rst_b)
      s_tc_hit |=> terminal_count;
  endproperty
  a_tc_out: assert property (p_tc_out)
    else $error("terminal count not entered");

  property p_reload_load;
    @(posedge clk_sys) disable iff (!rst_b)
      (s_tc_hit and !rel_bit) |=> st_r.count == $past(st_r.load);
  endproperty
  a_reload_load: assert property (p_reload_load)
    else $error("reload from load value missed");

  property p_reload_hold;
    @(posedge clk_sys) disable iff (!rst_b)
      (s_tc_hit and (rel_bit && !st_r.use_hold))
        |=> st_r.count == $past(st_r.hold);
  endproperty
  a_reload_hold: assert property (p_reload_hold)
    else $error("first reload in delayed pulse mode not from hold");

  property p_gate_block;
    @(posedge clk_sys) disable iff (!rst_b)
      (level_mode && !gate_lvl && !st_r.in_tc && !reg_wr)
        |=> st_r.count == $past(st_r.count);
  endproperty
  a_gate_block: assert property (p_gate_block)
    else $error("count moved with gate inactive");

  property p_inactive_edge;
    @(posedge clk_sys) disable iff (!rst_b)
      (!src_edge && !reg_wr) |=> st_r.count == $past(st_r.count);
  endproperty
  a_inactive_edge: assert property (p_inactive_edge)
    else $error("count moved without active source edge");

  property p_tc_counts;
    @(posedge clk_sys) disable iff (!rst_b)
      (st_r.in_tc && src_edge && !reg_wr) |=> !st_r.in_tc;
  endproperty
  a_tc_counts: assert property (p_tc_counts)
    else $error("terminal count state did not count");

  property p_oneshot_disarm;
    @(posedge clk_sys) disable iff (!rst_b)
      (st_r.in_tc && st_r.disarm_pend && src_edge && !reg_wr)
        |=> !st_r.armed;
  endproperty
  a_oneshot_disarm: assert property (p_oneshot_disarm)
    else $error("counter did not disarm after last terminal count");

  property p_edge_stop;
    @(posedge clk_sys) disable iff (!rst_b)
      (edge_mode && st_r.in_tc && st_r.stop_pend && src_edge && !reg_wr)
        |=> (st_r.armed && !st_r.running);
  endproperty
  a_edge_stop: assert property (p_edge_stop)
    else $error("one-shot did not halt armed");

endmodule : counter_mode_sequencer

// ---- src/ctr_seq_pkg.sv ----
// Package for the counter mode sequencer: register map, field layout,
// reset values and command codes.
// Assumes a single 50 MHz clock domain and a plain register port.
package ctr_seq_pkg;

  localparam int ADDR_W = 4;
  localparam int DATA_W = 16;

  // Register word offsets on the plain register port.
  localparam logic [3:0] OFS_MODE = 4'h0;
  localparam logic [3:0] OFS_LOAD = 4'h1;
  localparam logic [3:0] OFS_HOLD = 4'h2;
  localparam logic [3:0] OFS_CMD = 4'h3;
  localparam logic [3:0] OFS_COUNT = 4'h4;
  localparam logic [3:0] OFS_STATUS = 4'h5;
  localparam logic [3:0] OFS_IRQ_STAT = 4'h6;
  localparam logic [3:0] OFS_IRQ_MASK = 4'h7;

  // Fields of the counter operating mode register.
  localparam int GATE_CTL_HI = 15;
  localparam int GATE_CTL_LO = 13;
  localparam int SPECIAL_GATE_POS = 7;
  localparam int RELOAD_SRC_POS = 6;
  localparam int REPETITION_POS = 5;
  localparam int FLIP_OUT_POS = 0;
  localparam int GATE_POL_POS = 1;
  localparam int SRC_POL_POS = 2;

  // Gate control field: zero means no gating; the level and edge codes
  // are kept as parameters of plain value.
  localparam logic [2:0] GATE_NONE = 3'h0;
  localparam logic [2:0] GATE_LEVEL = 3'h1;
  localparam logic [2:0] GATE_EDGE = 3'h2;

  // Command register bit positions.
  localparam int CMD_ARM_POS = 0;
  localparam int CMD_DISARM_POS = 1;
  localparam int CMD_LOAD_POS = 2;

  // Interrupt status bit positions.
  localparam int IRQ_TC_POS = 0;
  localparam int IRQ_DISARM_POS = 1;
  localparam int IRQ_W = 2;

  // Reset values.
  localparam logic [15:0] MODE_RST = 16'h0000;
  localparam logic [15:0] LOAD_RST = 16'h0000;
  localparam logic [15:0] HOLD_RST = 16'h0000;
  localparam logic [15:0] COUNT_RST = 16'h0000;

  typedef enum logic [1:0] {
    SEQ_IDLE = 2'b00,
    SEQ_RUN = 2'b01,
    SEQ_TERM = 2'b11,
    SEQ_WAIT = 2'b10
  } seq_state_t;

endpackage : ctr_seq_pkg

// ---- src/pin_sync.sv ----
// Two-stage synchroniser with edge detection on the second stage.
// Assumes the input arrives from outside the clk_sys domain.
`timescale 1ns/1ps
module pin_sync
  import ctr_seq_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic pin_async,
  input wire logic active_high,
  output logic level,
  output logic rise
);

  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
  } sync_t;

  sync_t st_r;
  sync_t st_nxt;

  always_comb
  begin
    st_nxt.s1 = pin_async;
    st_nxt.s2 = st_r.s1;
    st_nxt.s3 = st_r.s2;
  end

  always_ff @(posedge clk_sys)
  begin
    if (!rst_b)
    begin
      st_r <= '0;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  // Active level after polarity; rise marks an active-going transition.
  assign level = st_r.s2 ~^ active_high;
  assign rise = (st_r.s2 ~^ active_high) & ~(st_r.s3 ~^ active_high);

endmodule : pin_sync

// ---- tb/pin_driver.sv ----
// Far-side model: drives the source and gate pins of the counter.
// Assumes one clk_sys domain; a pulse leaves the idle level for four
// cycles and returns to it for four more.
`timescale 1ns/1ps
module pin_driver
(
  input wire logic clk_sys,
  output logic source_pin,
  output logic gate_pin
);
  initial
  begin
    source_pin = 1'b0;
    gate_pin = 1'b0;
  end

  // Each pulse is wide enough for the pin synchroniser to see it; it
  // inverts the idle level so that either source polarity can be served.
  task automatic pulse(input int n);
    repeat (n)
    begin
      @(posedge clk_sys);
      source_pin <= ~source_pin;
      repeat (4) @(posedge clk_sys);
      source_pin <= ~source_pin;
      repeat (4) @(posedge clk_sys);
    end
  endtask : pulse

  // Moves the idle level of the source pin.
  task automatic hold_src(input logic lvl);
    @(posedge clk_sys);
    source_pin <= lvl;
    repeat (5) @(posedge clk_sys);
  endtask : hold_src

  task automatic gate(input logic lvl);
    @(posedge clk_sys);
    gate_pin <= lvl;
    repeat (5) @(posedge clk_sys);
  endtask : gate
endmodule : pin_driver

// ---- tb/counter_mode_sequencer_tb_top.sv ----
// Testbench for the counter mode sequencer: register tasks and modes.
// Assumes pin_driver as the far side on the source and gate pins.
`timescale 1ns/1ps
module counter_mode_sequencer_tb_top
  import ctr_seq_pkg::*;
;
  logic clk_sys;
  logic rst_b;
  logic [ADDR_W-1:0] reg_addr;
  logic [DATA_W-1:0] reg_wdata;
  logic reg_wr;
  logic reg_rd;
  logic [DATA_W-1:0] reg_rdata;
  logic source_pin;
  logic gate_pin;
  logic terminal_count;
  logic terminal_count_flip_output;
  logic irq;
  logic [DATA_W-1:0] d;
  logic f0;
  int failures;
  int num_checks;

  counter_mode_sequencer dut_u (
    .clk_sys(clk_sys),
    .rst_b(rst_b),
    .reg_addr(reg_addr),
    .reg_wdata(reg_wdata),
    .reg_wr(reg_wr),
    .reg_rd(reg_rd),
    .reg_rdata(reg_rdata),
    .source_pin(source_pin),
    .gate_pin(gate_pin),
    .terminal_count(terminal_count),
    .terminal_count_flip_output(terminal_count_flip_output),
    .irq(irq)
  );

  pin_driver pins_u (
    .clk_sys(clk_sys),
    .source_pin(source_pin),
    .gate_pin(gate_pin)
  );

  initial
  begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end

  ////////////////////////////////////////////////////////////////////
  task automatic wr(input logic [3:0] a, input logic [15:0] v);
    @(posedge clk_sys);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask : wr

  // Read data stand only in the cycle after the strobe.
  task automatic rd(input logic [3:0] a);
    @(posedge clk_sys);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1;
    d = reg_rdata;
  endtask : rd

  task automatic chk_reg(input logic [15:0] g, input logic [15:0] e);
    num_checks++;
    if (g !== e)
    begin
      failures++;
      $display("[ERR] %0t reg got %h exp %h", $time, g, e);
    end
  endtask : chk_reg

  task automatic chk_pin(input logic g, input logic e);
    num_checks++;
    if (g !== e)
    begin
      failures++;
      $display("[ERR] %0t pin got %b exp %b", $time, g, e);
    end
  endtask : chk_pin

  task automatic rd_chk(input logic [3:0] a, input logic [15:0] e);
    rd(a);
    chk_reg(d, e);
  endtask : rd_chk

  task automatic armed_is(input logic e);
    rd(OFS_STATUS);
    chk_reg(d & 16'h0001, {15'h0000, e});
  endtask : armed_is

  // Mode first, then Load, then a load command to preset the count.
  task automatic setup(input logic [15:0] m, input logic [15:0] ld);
    wr(OFS_MODE, m);
    wr(OFS_LOAD, ld);
    wr(OFS_CMD, 16'h0004);
    wr(OFS_CMD, 16'h0001);
  endtask : setup

  task automatic done(input string s);
    $display("test %s done", s);
  endtask : done

  task automatic wrap_up;
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : wrap_up

  initial
  begin
    repeat (20000) @(posedge clk_sys);
    failures++;
    $display("[ERR] %0t run did not finish", $time);
    wrap_up();
  end

  ////////////////////////////////////////////////////////////////////
  initial
  begin
    failures = 0;
    num_checks = 0;
    rst_b = 1'b0;
    reg_addr = 4'h0;
    reg_wdata = 16'h0000;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    repeat (12) @(posedge clk_sys);
    rst_b <= 1'b1;
    repeat (3) @(posedge clk_sys);
    rd_chk(OFS_MODE, MODE_RST);
    rd_chk(OFS_HOLD, HOLD_RST);
    rd_chk(OFS_COUNT, COUNT_RST);
    wr(4'h8, 16'hffff);
    rd_chk(4'h8, 16'h0000);
    wr(OFS_COUNT, 16'h0055);
    rd_chk(OFS_COUNT, COUNT_RST);
    done("reset");
    wr(OFS_IRQ_MASK, 16'h0001);
    setup(16'h0000, 16'h0003);
    pins_u.pulse(2);
    rd_chk(OFS_COUNT, 16'h0001);
    pins_u.pulse(1);
    rd_chk(OFS_COUNT, 16'h0003);
    chk_pin(terminal_count, 1'b1);
    chk_pin(irq, 1'b1);
    pins_u.pulse(2);
    rd_chk(OFS_COUNT, 16'h0002);
    armed_is(1'b0);
    rd_chk(OFS_IRQ_STAT, 16'h0003);
    wr(OFS_IRQ_STAT, 16'h0003);
    rd_chk(OFS_IRQ_STAT, 16'h0000);
    chk_pin(irq, 1'b0);
    wr(OFS_IRQ_MASK, 16'h0000);
    done("ungated strobe");
    setup(16'h2000, 16'h0003);
    pins_u.pulse(2);
    rd_chk(OFS_COUNT, 16'h0003);
    pins_u.gate(1'b1);
    pins_u.pulse(3);
    rd_chk(OFS_COUNT, 16'h0003);
    pins_u.pulse(1);
    armed_is(1'b0);
    pins_u.gate(1'b0);
    done("level strobe");
    setup(16'h0021, 16'h0002);
    f0 = terminal_count_flip_output;
    pins_u.pulse(2);
    rd_chk(OFS_COUNT, 16'h0002);
    chk_pin(terminal_count_flip_output, ~f0);
    pins_u.gate(1'b1);
    pins_u.pulse(2);
    chk_pin(terminal_count_flip_output, f0);
    armed_is(1'b1);
    chk_pin(irq, 1'b0);
    wr(OFS_CMD, 16'h0002);
    // A disarmed counter still leaves terminal count on the next edge.
    pins_u.pulse(1);
    rd_chk(OFS_COUNT, 16'h0001);
    chk_pin(terminal_count, 1'b0);
    pins_u.gate(1'b0);
    done("rate");
    setup(16'h2020, 16'h0002);
    pins_u.pulse(1);
    rd_chk(OFS_COUNT, 16'h0002);
    pins_u.gate(1'b1);
    pins_u.pulse(1);
    rd_chk(OFS_COUNT, 16'h0001);
    wr(OFS_CMD, 16'h0002);
    pins_u.gate(1'b0);
    done("gated rate");
    setup(16'h4020, 16'h0002);
    pins_u.pulse(1);
    rd_chk(OFS_COUNT, 16'h0002);
    pins_u.gate(1'b1);
    pins_u.pulse(1);
    rd_chk(OFS_COUNT, 16'h0001);
    pins_u.gate(1'b0);
    pins_u.gate(1'b1);
    pins_u.pulse(1);
    rd_chk(OFS_COUNT, 16'h0002);
    pins_u.pulse(2);
    rd_chk(OFS_COUNT, 16'h0001);
    armed_is(1'b1);
    wr(OFS_CMD, 16'h0002);
    pins_u.gate(1'b0);
    done("one shot");
    wr(OFS_HOLD, 16'h0003);
    setup(16'h0041, 16'h0002);
    f0 = terminal_count_flip_output;
    pins_u.pulse(2);
    rd_chk(OFS_COUNT, 16'h0003);
    chk_pin(terminal_count_flip_output, ~f0);
    pins_u.pulse(3);
    rd_chk(OFS_COUNT, 16'h0002);
    chk_pin(terminal_count_flip_output, f0);
    pins_u.pulse(2);
    rd_chk(OFS_COUNT, 16'h0001);
    armed_is(1'b0);
    wr(OFS_CMD, 16'h0001);
    pins_u.pulse(1);
    rd_chk(OFS_COUNT, 16'h0003);
    done("delayed pulse");
    wr(OFS_CMD, 16'h0002);
    pins_u.pulse(1);
    rd_chk(OFS_COUNT, 16'h0002);
    // Active-low source and gate in the level-gated rate mode.
    setup(16'h2026, 16'h0002);
    pins_u.hold_src(1'b1);
    rd_chk(OFS_COUNT, 16'h0002);
    pins_u.pulse(1);
    rd_chk(OFS_COUNT, 16'h0001);
    pins_u.gate(1'b1);
    pins_u.pulse(1);
    rd_chk(OFS_COUNT, 16'h0001);
    pins_u.gate(1'b0);
    pins_u.pulse(1);
    rd_chk(OFS_COUNT, 16'h0002);
    chk_pin(terminal_count, 1'b1);
    wr(OFS_CMD, 16'h0002);
    done("polarity");
    wrap_up();
  end
endmodule : counter_mode_sequencer_tb_top
